/* File: src/dma_channel_request_regs.sv */
// Module: channel request registers of a three-channel DMA controller
`timescale 1ns/10ps
//
// Contract
// RULE1: Read-only 32-bit alternate control-structure base, value from controller, writes ignored.
// RULE2: Read-only 3-bit field shows each channel's wait-on-request state.
// RULE3: Write-only 3-bit software request; one in bit n requests channel n.
// RULE4: With burst-only set, the channel's single request input is ignored.
// RULE5: Reading burst-only set register returns each channel's burst-only state.
// RULE6: Writing zero to burst-only set leaves that channel's state unchanged.
// RULE7: Write-only clear register; one in bit n clears channel n burst-only.
// RULE8: Controller clears burst-only itself when last partial group remains.
// RULE9: Software request zero bits do nothing; ones give one-cycle pulses only.
module dma_channel_request_regs
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire dma_req_pkg::avalon_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Peripheral request lines
    input wire dma_req_pkg::periph_req_t periph_req,
    // Channel engine status
    input wire dma_req_pkg::engine_status_t engine_status,
    // Requests toward the channel logic
    output logic [2:0] channel_request,
    output logic [2:0] burst_only
);

    // ********************************
    // Bus handshake
    // ********************************
    logic access_done;
    logic bus_active;
    logic wr_ok;

    // Any access pending; writes only act in the taking cycle on lane 0
    assign bus_active = avs_req.read | avs_req.write;
    assign wr_ok = avs_req.write & avs_waitrequest & bus_active & avs_req.byteenable[0];

    // Wait one cycle, then answer; waitrequest low for one cycle per access
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_waitrequest <= dma_req_pkg::waitrequest_reset;
        else if (bus_active && avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    // Taking cycle: request present while waitrequest still high
    assign access_done = bus_active & avs_waitrequest;

    // Full 32-bit address match, shared by every decoder below
    function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
        hit = (a == target);
    endfunction : hit

    // ********************************
    // Read data
    // ********************************
    // Read word loaded at the taking edge, held until the next read
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_readdata <= dma_req_pkg::read_data_reset;
        else if (access_done && avs_req.read)
        begin
            if (hit(avs_req.address, dma_req_pkg::alternate_structure_base_addr))
                avs_readdata <= engine_status.alt_base; // [RULE1]
            else if (hit(avs_req.address, dma_req_pkg::channel_wait_request_flags_addr))
                avs_readdata <= {29'h0, engine_status.wait_on_request}; // [RULE2]
            else if (hit(avs_req.address, dma_req_pkg::burst_only_set_addr))
                avs_readdata <= {29'h0, burst_only}; // [RULE5]
            else
                avs_readdata <= dma_req_pkg::unmapped_read_value;
        end
    end

    // ********************************
    // Burst-only state
    // ********************************
    logic [2:0] set_bits;
    logic [2:0] clr_bits;

    // Set and clear masks; zero bits of either write leave state alone
    assign set_bits = (wr_ok && hit(avs_req.address, dma_req_pkg::burst_only_set_addr)) ?
                      avs_req.writedata[2:0] : 3'h0; // [RULE6]
    assign clr_bits = ((wr_ok && hit(avs_req.address, dma_req_pkg::burst_only_clear_addr)) ?
                      avs_req.writedata[2:0] : 3'h0) | engine_status.group_tail_done; // [RULE7] [RULE8]

    // Software set wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            burst_only <= dma_req_pkg::burst_only_reset;
        else
            burst_only <= (burst_only & ~clr_bits) | set_bits; // [RULE6] [RULE7] [RULE8]
    end

    // ********************************
    // Channel request generation
    // ********************************
    logic [2:0] sw_pulse;

    // Software request lasts only for the taking cycle, never stored
    assign sw_pulse = (wr_ok && hit(avs_req.address, dma_req_pkg::software_channel_request_addr)) ?
                      avs_req.writedata[2:0] : 3'h0; // [RULE3] [RULE9]

    // Burst lines always count; single lines only where burst-only is clear
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            channel_request <= dma_req_pkg::channel_request_reset;
        else
            channel_request <= periph_req.burst | (periph_req.single & ~burst_only) | sw_pulse; // [RULE4] [RULE3]
    end

    // ********************************
    // Assertions: bus handshake and read data
    // ********************************

    answer_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        access_done |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest timing wrong");

    idle_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !bus_active |=> avs_waitrequest)
        else $error("waitrequest low while idle");

    readdata_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(access_done && avs_req.read) |=> $stable(avs_readdata))
        else $error("read data changed without read");

    alt_base_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE1]
        (access_done && avs_req.read && hit(avs_req.address, dma_req_pkg::alternate_structure_base_addr))
        |=> (avs_readdata == $past(engine_status.alt_base) && !avs_waitrequest))
        else $error("alternate base read wrong");

    wait_flags_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE2]
        (access_done && avs_req.read && hit(avs_req.address, dma_req_pkg::channel_wait_request_flags_addr))
        |=> avs_readdata == {29'h0, $past(engine_status.wait_on_request)})
        else $error("wait flags read wrong");

    burst_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5]
        (access_done && avs_req.read && hit(avs_req.address, dma_req_pkg::burst_only_set_addr))
        |=> avs_readdata == {29'h0, $past(burst_only)})
        else $error("burst-only read wrong");

    read_no_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (avs_req.read && !avs_req.write) |-> (sw_pulse == 3'h0 && set_bits == 3'h0))
        else $error("read changed register state");

    lane_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (avs_req.write && !avs_req.byteenable[0]) |-> (sw_pulse == 3'h0 && set_bits == 3'h0))
        else $error("write without lane 0 took effect");

    // ********************************
    // Assertions: burst-only state
    // ********************************

    set_zero_keeps_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
        (burst_only[1] && clr_bits[1] == 1'b0) |=> burst_only[1])
        else $error("burst-only bit lost without clear");

    set_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
        set_bits != 3'h0 |=> (burst_only & $past(set_bits)) == $past(set_bits))
        else $error("burst-only set write ignored");

    clear_reg_works_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE7]
        (clr_bits & ~set_bits) != 3'h0 |=> (burst_only & $past(clr_bits & ~set_bits)) == 3'h0)
        else $error("burst-only clear ignored");

    clear_no_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE7]
        (clr_bits != 3'h0 && set_bits == 3'h0) |=> (burst_only & ~$past(burst_only)) == 3'h0)
        else $error("burst-only clear raised a bit");

    tail_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE8]
        (engine_status.group_tail_done[0] && !set_bits[0]) |=> !burst_only[0])
        else $error("tail completion did not clear burst-only");

    // ********************************
    // Assertions: channel requests
    // ********************************

    burst_single_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE4]
        (burst_only & periph_req.single & ~periph_req.burst & ~sw_pulse) != 3'h0
        |=> (channel_request & $past(burst_only & periph_req.single & ~periph_req.burst & ~sw_pulse)) == 3'h0)
        else $error("single request passed while burst-only set");

    burst_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE4]
        periph_req.burst != 3'h0 |=> (channel_request & $past(periph_req.burst)) == $past(periph_req.burst))
        else $error("burst request lost");

    single_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE4]
        (periph_req.single & ~burst_only) != 3'h0
        |=> (channel_request & $past(periph_req.single & ~burst_only)) == $past(periph_req.single & ~burst_only))
        else $error("single request lost while burst-only clear");

    sw_request_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE3]
        sw_pulse != 3'h0 |=> (channel_request & $past(sw_pulse)) == $past(sw_pulse))
        else $error("software request not issued");

    sw_zero_nop_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9]
        (periph_req.burst == 3'h0 && periph_req.single == 3'h0 && sw_pulse == 3'h0) |=> channel_request == 3'h0)
        else $error("request without cause");

    sw_pulse_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9]
        sw_pulse != 3'h0 |=> sw_pulse == 3'h0)
        else $error("software request held");

    sw_pulse_source_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9]
        sw_pulse != 3'h0 |-> (access_done && avs_req.write))
        else $error("software request without write");

    // ********************************
    // Cover points
    // ********************************

    cover_sw_request_c: cover property (@(posedge ref_clk) disable iff (!rst_n) sw_pulse != 3'h0);
    cover_burst_set_c: cover property (@(posedge ref_clk) disable iff (!rst_n) set_bits != 3'h0);
    cover_tail_clear_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        burst_only[0] && engine_status.group_tail_done[0]);
    cover_blocked_single_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        burst_only[2] && periph_req.single[2]);
    cover_read_answer_c: cover property (@(posedge ref_clk) disable iff (!rst_n) access_done && avs_req.read);

endmodule : dma_channel_request_regs

/* File: src/dma_req_pkg.sv */
// Package: register map, field layouts and carrier types for the channel request registers
package dma_req_pkg;

    // ********************************
    // Register map (byte addresses)
    // ********************************
    localparam logic [31:0] alternate_structure_base_addr = 32'h4080000c;
    localparam logic [31:0] channel_wait_request_flags_addr = 32'h40800010;
    localparam logic [31:0] software_channel_request_addr = 32'h40800014;
    localparam logic [31:0] burst_only_set_addr = 32'h40800018;
    localparam logic [31:0] burst_only_clear_addr = 32'h4080001c;

    // ********************************
    // Widths and reset values
    // ********************************
    localparam int channels = 3;
    localparam logic [2:0] burst_only_reset = 3'h0;
    localparam logic [2:0] channel_request_reset = 3'h0;
    localparam logic waitrequest_reset = 1'h1;
    localparam logic [31:0] read_data_reset = 32'h00000000;
    localparam logic [31:0] unmapped_read_value = 32'h00000000;

    // Avalon-MM request as seen by the slave
    typedef struct packed {
        logic [31:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } avalon_req_t;

    // Per-channel request lines from peripherals
    typedef struct packed {
        logic [2:0] burst;
        logic [2:0] single;
    } periph_req_t;

    // Status inputs from the channel engine
    typedef struct packed {
        logic [31:0] alt_base;
        logic [2:0] wait_on_request;
        logic [2:0] group_tail_done;
    } engine_status_t;

endpackage : dma_req_pkg

/* File: sim/periph_model.sv */
// Peripheral model driving per-channel burst and single request lines
`timescale 1ns/10ps
module periph_model
(
    // Clock
    input wire logic ref_clk,
    // Wanted line levels from the bench
    input wire logic [2:0] want_burst,
    input wire logic [2:0] want_single,
    // Lines toward the block
    output dma_req_pkg::periph_req_t periph_req
);
    // Lines idle low, change just after an edge and are held as levels
    initial periph_req = '0;
    always @(posedge ref_clk)
        periph_req <= '{burst: want_burst, single: want_single};
endmodule : periph_model

/* File: sim/dma_channel_request_regs_bench.sv */
// Bench for the channel request registers
`timescale 1ns/10ps
module dma_channel_request_regs_bench;
    localparam logic [31:0] set_a = dma_req_pkg::burst_only_set_addr;
    localparam logic [31:0] clr_a = dma_req_pkg::burst_only_clear_addr;
    localparam logic [31:0] sw_a = dma_req_pkg::software_channel_request_addr;
    localparam logic [31:0] alt_a = dma_req_pkg::alternate_structure_base_addr;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    dma_req_pkg::avalon_req_t avs_req = '0;
    dma_req_pkg::engine_status_t engine_status = '0;
    dma_req_pkg::periph_req_t periph_req;
    logic [2:0] want_burst = 3'h0;
    logic [2:0] want_single = 3'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] channel_request;
    logic [2:0] burst_only;
    logic [2:0] pulse_seen;
    logic [31:0] rd;
    int error_cnt = 0;
    int cmp_count = 0;
    int cycles = 0;
    // 200 MHz clock
    initial forever #2.5 ref_clk = ~ref_clk;
    periph_model peer (.ref_clk(ref_clk), .want_burst(want_burst), .want_single(want_single), .periph_req(periph_req));
    dma_channel_request_regs dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_req(avs_req), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .periph_req(periph_req), .engine_status(engine_status),
        .channel_request(channel_request), .burst_only(burst_only));
    // Compare and count
    task check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
        end
    endtask : check
    // One access held until waitrequest is sampled low
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
        int waits;
        waits = 0;
        @(posedge ref_clk);
        avs_req <= '{address: a, read: ~wr, write: wr, byteenable: be, writedata: d};
        do
        begin
            @(posedge ref_clk);
            waits++;
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        pulse_seen = channel_request;
        avs_req <= '0;
        #1;
        check(waits, 2);
        check(32'(avs_waitrequest), 32'h1);
    endtask : bus
    // Peripheral line levels, seen two edges later
    task lines(input logic [2:0] b, input logic [2:0] s);
        @(posedge ref_clk);
        want_burst <= b;
        want_single <= s;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : lines
    // Read-only fields, ignored write, unmapped read
    task t_status;
        @(posedge ref_clk);
        engine_status <= '{alt_base: 32'h13579bd0, wait_on_request: 3'h5, group_tail_done: 3'h0};
        bus(1'b0, alt_a, 32'h0, 4'hf);
        check(rd, 32'h13579bd0);
        bus(1'b1, alt_a, 32'hffffffff, 4'hf);
        bus(1'b0, alt_a, 32'h0, 4'hf);
        check(rd, 32'h13579bd0);
        bus(1'b0, dma_req_pkg::channel_wait_request_flags_addr, 32'h0, 4'hf);
        check(rd, 32'h5);
        bus(1'b0, 32'h40800030, 32'h0, 4'hf);
        check(rd, 32'h0);
    endtask : t_status
    // Software request pulses, zeros and disabled lane
    task t_soft;
        bus(1'b1, sw_a, 32'h5, 4'hf);
        check(32'(pulse_seen), 32'h5);
        check(32'(channel_request), 32'h0);
        bus(1'b1, sw_a, 32'h0, 4'hf);
        check(32'(pulse_seen), 32'h0);
        bus(1'b1, sw_a, 32'h2, 4'h0);
        check(32'(pulse_seen), 32'h0);
    endtask : t_soft
    // Burst-only set, masking, zero write, clear
    task t_burst;
        bus(1'b0, set_a, 32'h0, 4'hf);
        check(rd, 32'h0);
        bus(1'b1, set_a, 32'h2, 4'hf);
        lines(3'h0, 3'h7);
        check(32'(channel_request), 32'h5);
        lines(3'h2, 3'h7);
        check(32'(channel_request), 32'h7);
        bus(1'b1, set_a, 32'h0, 4'hf);
        bus(1'b0, set_a, 32'h0, 4'hf);
        check(rd, 32'h2);
        bus(1'b1, clr_a, 32'h2, 4'hf);
        check(32'(burst_only), 32'h0);
        lines(3'h0, 3'h7);
        check(32'(channel_request), 32'h7);
        lines(3'h0, 3'h0);
    endtask : t_burst
    // Controller clears burst-only on a partial last group
    task t_tail;
        bus(1'b1, set_a, 32'h7, 4'hf);
        @(posedge ref_clk);
        engine_status.group_tail_done <= 3'h1;
        @(posedge ref_clk);
        engine_status.group_tail_done <= 3'h0;
        #1;
        check(32'(burst_only), 32'h6);
    endtask : t_tail
    // Verdict and end of run
    task finish_test;
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // Hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    // Main sequence
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_status();
        t_soft();
        t_burst();
        t_tail();
        finish_test();
    end
endmodule : dma_channel_request_regs_bench
